// ===== design/pdsc_group.sv
`timescale 1ns/1ns
module pdsc_group (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 cap_i,
  input  pdsc_pkg::pdsc_strap_t     strap_i,
  input  wire logic                 ctrl_we_i,
  input  wire logic                 out_we_i,
  input  wire logic [3:0]           be_i,
  input  wire logic [31:0]          wdata_i,
  output logic [7:0]                ctrl_o,
  output logic [23:0]               out_o,
  output logic [23:0]               oe_o,
  output logic [3:0]                dir_o
);

  logic [7:0]  ctrl_q;
  logic [23:0] out_q;
  logic [23:0] oe_q;
  logic [3:0]  dir_q;
  logic [3:0]  dir_d;
  logic [23:0] lvl_d;
  logic [23:0] wmask;

  // Software control word, starts with every section as input
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= pdsc_pkg::CW_RESET;
    end else if (ctrl_we_i && be_i[0]) begin
      ctrl_q <= wdata_i[7:0] & pdsc_pkg::CW_MASK;
    end
  end

  // Effective direction and catch value per section
  always_comb begin
    dir_d = '0;
    lvl_d = pdsc_pkg::OUT_RESET;
    for (int unsigned s = 0; s < pdsc_pkg::SECT_N; s++) begin
      // Forced sections ignore the control word
      dir_d[s] = strap_i.force_out[s] | ~ctrl_q[pdsc_pkg::sect_cw_bit(s)];
      if (strap_i.force_out[s] && !strap_i.level[s]) begin
        lvl_d = lvl_d & ~pdsc_pkg::sect_mask(s);
      end
    end
  end

  // Byte lanes of the output latch
  always_comb begin
    wmask = {{8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};
  end

  // Output latch: preset at capture, then software owned
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= pdsc_pkg::OUT_RESET;
    end else if (cap_i) begin
      out_q <= lvl_d;
    end else if (out_we_i) begin
      out_q <= (out_q & ~wmask) | (wdata_i[23:0] & wmask);
    end
  end

  // Registered enables so pins come straight from flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= '0;
      oe_q  <= '0;
    end else begin
      dir_q <= dir_d;
      oe_q  <= {{4{dir_d[pdsc_pkg::SEC_CU]}}, {4{dir_d[pdsc_pkg::SEC_CL]}},
               {8{dir_d[pdsc_pkg::SEC_B]}}, {8{dir_d[pdsc_pkg::SEC_A]}}};
    end
  end

  assign ctrl_o = ctrl_q;
  assign out_o  = out_q;
  assign oe_o   = oe_q;
  assign dir_o  = dir_q;

endmodule

// ===== design/pdsc_pkg.sv
// What this block does
// - Direction switch ON forces output, ignores software
// - Direction switch OFF gives software direction control
// - Forced port starts high if level switch ON
// - Level switch matters only for forced ports
// - Four switches give identifier; ON reads 0
// - Four sections forced independently: A, B, C halves
// - Second group has its own forcing switches
// - Each group has own per-section level switches
// - Software ports start as inputs, level high
package pdsc_pkg;

  // ***************************************************
  // Geometry
  // ***************************************************
  localparam int unsigned GROUP_W   = 24;
  localparam int unsigned SECT_N    = 4;
  // Section index order: port A, port B, port C upper, port C lower
  localparam int unsigned SEC_A     = 0;
  localparam int unsigned SEC_B     = 1;
  localparam int unsigned SEC_CU    = 2;
  localparam int unsigned SEC_CL    = 3;

  // ***************************************************
  // Control word bit positions (1 = input, 0 = output)
  // ***************************************************
  localparam int unsigned CW_A_BIT  = 4;
  localparam int unsigned CW_CU_BIT = 3;
  localparam int unsigned CW_B_BIT  = 1;
  localparam int unsigned CW_CL_BIT = 0;
  localparam logic [7:0]  CW_RESET  = 8'h1b;
  localparam logic [7:0]  CW_MASK   = 8'h1b;

  // ***************************************************
  // Register byte offsets
  // ***************************************************
  localparam logic [4:0] OFF_CTRL_G0 = 5'h00;
  localparam logic [4:0] OFF_CTRL_G1 = 5'h04;
  localparam logic [4:0] OFF_OUT_G0  = 5'h08;
  localparam logic [4:0] OFF_OUT_G1  = 5'h0c;
  localparam logic [4:0] OFF_IN_G0   = 5'h10;
  localparam logic [4:0] OFF_IN_G1   = 5'h14;
  localparam logic [4:0] OFF_STRAP   = 5'h18;
  localparam logic [4:0] OFF_DIR     = 5'h1c;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [23:0] OUT_RESET   = 24'hffffff;
  localparam logic [3:0]  IDENT_RESET = 4'h0;
  localparam int unsigned RST_STAGES  = 2;

  // Switch settings of one port group, 1 = switch ON
  typedef struct packed {
    logic [3:0] force_out;
    logic [3:0] level;
  } pdsc_strap_t;

  // Pin bit mask of one section within a group
  function automatic logic [23:0] sect_mask(input int unsigned sec);
    logic [23:0] m;
    m = 24'h000000;
    case (sec)
      SEC_A:   m = 24'h0000ff;
      SEC_B:   m = 24'h00ff00;
      SEC_CU:  m = 24'hf00000;
      default: m = 24'h0f0000;
    endcase
    return m;
  endfunction

  // Control word bit that steers one section
  function automatic int unsigned sect_cw_bit(input int unsigned sec);
    int unsigned b;
    b = CW_CL_BIT;
    case (sec)
      SEC_A:   b = CW_A_BIT;
      SEC_B:   b = CW_B_BIT;
      SEC_CU:  b = CW_CU_BIT;
      default: b = CW_CL_BIT;
    endcase
    return b;
  endfunction

endpackage

// ===== design/pdsc_rst_sync.sv
`timescale 1ns/1ns
module pdsc_rst_sync #(
  parameter int unsigned STAGES = pdsc_pkg::RST_STAGES
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  output logic      rst_n_o
);

  logic [STAGES-1:0] sync_q;

  // Assert at once, release after STAGES clean edges
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], 1'b1};
    end
  end

  assign rst_n_o = sync_q[STAGES-1];

endmodule

// ===== design/pdsc_top.sv
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module pdsc_top #(
  parameter int unsigned GROUPS = 2
) (
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  input  wire logic [4:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic [3:0]         direction_force_switch_group0_i,
  input  wire logic [3:0]         direction_force_switch_group1_i,
  input  wire logic [3:0]         output_level_switch_group0_i,
  input  wire logic [3:0]         output_level_switch_group1_i,
  input  wire logic [3:0]         board_ident_switch_i,
  input  wire logic [47:0]        field_pins_i,
  output logic [47:0]             field_pins_o,
  output logic [47:0]             field_pins_oe_o,
  output logic [3:0]              board_ident_o
);

  // ***************************************************
  // Reset and switch capture
  // ***************************************************
  logic                  rst_n;
  logic                  cap_q;
  logic                  preset_q;
  logic [3:0]            ident_q;
  pdsc_pkg::pdsc_strap_t strap_q [2];

  pdsc_rst_sync #(
    .STAGES (pdsc_pkg::RST_STAGES)
  ) u_rst (
    .clk_i   (sys_clk_i),
    .nrst_i  (nrst_i),
    .rst_n_o (rst_n)
  );

  // One capture pulse on the first edge after reset release
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= 1'b1;
    end else begin
      cap_q <= 1'b0;
    end
  end

  // Output latch preset one edge later, once the held switches are valid
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      preset_q <= 1'b0;
    end else begin
      preset_q <= cap_q;
    end
  end

  // Switch levels held from capture until the next reset
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_q[0] <= '0;
      strap_q[1] <= '0;
      ident_q    <= pdsc_pkg::IDENT_RESET;
    end else if (cap_q) begin
      strap_q[0] <= {direction_force_switch_group0_i, output_level_switch_group0_i};
      strap_q[1] <= {direction_force_switch_group1_i, output_level_switch_group1_i};
      ident_q    <= ~board_ident_switch_i;
    end
  end

  // ***************************************************
  // Avalon-MM slave, one wait cycle per access
  // ***************************************************
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        commit;
  logic [31:0] rdata_d;
  logic [7:0]  ctrl    [2];
  logic [23:0] outv    [2];
  logic [23:0] oev     [2];
  logic [3:0]  dirv    [2];
  logic [47:0] pins_q;

  assign acc    = avs_read_i | avs_write_i;
  assign commit = acc & ~wait_q;

  // Waitrequest drops for one cycle after the request is seen
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(acc & wait_q);
    end
  end

  // Pin sampling for read-back
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= '0;
    end else begin
      pins_q <= field_pins_i;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h00000000;
    case (avs_address_i)
      pdsc_pkg::OFF_CTRL_G0: rdata_d = {24'h000000, ctrl[0]};
      pdsc_pkg::OFF_CTRL_G1: rdata_d = {24'h000000, ctrl[1]};
      pdsc_pkg::OFF_OUT_G0:  rdata_d = {8'h00, outv[0]};
      pdsc_pkg::OFF_OUT_G1:  rdata_d = {8'h00, outv[1]};
      pdsc_pkg::OFF_IN_G0:   rdata_d = {8'h00, pins_q[23:0]};
      pdsc_pkg::OFF_IN_G1:   rdata_d = {8'h00, pins_q[47:24]};
      pdsc_pkg::OFF_STRAP:   rdata_d = {12'h000, strap_q[1], strap_q[0], ident_q};
      pdsc_pkg::OFF_DIR:     rdata_d = {24'h000000, dirv[1], dirv[0]};
      default:               rdata_d = 32'h00000000;
    endcase
  end

  // Read data latched while waitrequest is high
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ***************************************************
  // Port groups
  // ***************************************************
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    logic ctrl_we;
    logic out_we;
    assign ctrl_we = commit & avs_write_i &
                     (avs_address_i == (g == 0 ? pdsc_pkg::OFF_CTRL_G0
                                               : pdsc_pkg::OFF_CTRL_G1));
    assign out_we  = commit & avs_write_i &
                     (avs_address_i == (g == 0 ? pdsc_pkg::OFF_OUT_G0
                                               : pdsc_pkg::OFF_OUT_G1));
    pdsc_group u_grp (
      .clk_i     (sys_clk_i),
      .rst_n_i   (rst_n),
      .cap_i     (preset_q),
      .strap_i   (strap_q[g]),
      .ctrl_we_i (ctrl_we),
      .out_we_i  (out_we),
      .be_i      (avs_byteenable_i),
      .wdata_i   (avs_writedata_i),
      .ctrl_o    (ctrl[g]),
      .out_o     (outv[g]),
      .oe_o      (oev[g]),
      .dir_o     (dirv[g])
    );
  end

  // ***************************************************
  // Outputs, all from flops
  // ***************************************************
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign field_pins_o      = {outv[1], outv[0]};
  assign field_pins_oe_o   = {oev[1], oev[0]};
  assign board_ident_o     = ident_q;

endmodule

// ===== verif/pdsc_assertions.sv
`timescale 1ns/1ns
module pdsc_checker (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [3:0]  direction_force_switch_group0_i,
  input wire logic [3:0]  direction_force_switch_group1_i,
  input wire logic [3:0]  output_level_switch_group0_i,
  input wire logic [3:0]  output_level_switch_group1_i,
  input wire logic [3:0]  board_ident_switch_i,
  input wire logic [47:0] field_pins_o,
  input wire logic [47:0] field_pins_oe_o,
  input wire logic [3:0]  board_ident_o
);
  logic [2:0]  cnt_q;
  logic [47:0] fm;
  logic [47:0] lv;
  // Section switch bits spread over pin positions
  function automatic logic [23:0] smask(input logic [3:0] s);
    return {{4{s[2]}}, {4{s[3]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  assign fm = {smask(direction_force_switch_group1_i), smask(direction_force_switch_group0_i)};
  assign lv = {smask(output_level_switch_group1_i), smask(output_level_switch_group0_i)};
  // Cycles since reset release, saturating
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_start_dir: assert property (cnt_q == 3'h5 |-> field_pins_oe_o == fm)
    else $error("start direction wrong");
  a_start_level: assert property (cnt_q == 3'h5 |-> field_pins_o == ((fm & lv) | ~fm))
    else $error("start level wrong");
  a_forced_oe: assert property (cnt_q == 3'h7 |-> (field_pins_oe_o & fm) == fm)
    else $error("forced section released");
  a_ident_value: assert property (cnt_q == 3'h7 |-> board_ident_o == ~board_ident_switch_i)
    else $error("identifier wrong");
  a_ident_held: assert property (cnt_q == 3'h7 |-> $stable(board_ident_o))
    else $error("identifier moved");
  a_oe_cause: assert property (cnt_q == 3'h7 && $changed(field_pins_oe_o) |-> $past(avs_write_i, 2))
    else $error("direction moved without write");
  a_wait_one: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("wait low too long");
  a_req_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    && cnt_q == 3'h7 |=> !avs_waitrequest_o)
    else $error("request not answered");
  a_idle_wait: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("wait low at idle");
endmodule
bind pdsc_top pdsc_checker chk_i (.sys_clk_i, .nrst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .direction_force_switch_group0_i, .direction_force_switch_group1_i,
  .output_level_switch_group0_i, .output_level_switch_group1_i, .board_ident_switch_i,
  .field_pins_o, .field_pins_oe_o, .board_ident_o);

// ===== verif/pdsc_field_model.sv
`timescale 1ns/1ns
module pdsc_field_model (
  input  wire logic [47:0] oe_i,
  input  wire logic [47:0] drv_i,
  input  wire logic [47:0] ext_i,
  output logic [47:0]      pins_o
);
  // Driven lines follow the card, released lines carry the field pattern
  assign pins_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// ===== verif/port_direction_strap_config_test.sv
`timescale 1ns/1ns
module port_direction_strap_config_test;
  logic        clk, nrst, rd, wr, waitreq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  f0, f1, l0, l1, sid, ident;
  logic [47:0] ext, pin_i, pin_o, pin_oe;
  int          bad_count, n_compared;
  pdsc_top uut (.sys_clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .direction_force_switch_group0_i(f0), .direction_force_switch_group1_i(f1),
    .output_level_switch_group0_i(l0), .output_level_switch_group1_i(l1),
    .board_ident_switch_i(sid), .field_pins_i(pin_i), .field_pins_o(pin_o),
    .field_pins_oe_o(pin_oe), .board_ident_o(ident));
  pdsc_field_model fld (.oe_i(pin_oe), .drv_i(pin_o), .ext_i(ext), .pins_o(pin_i));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [23:0] smask(input logic [3:0] s);
    return {{4{s[2]}}, {4{s[3]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    got = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic boot(input logic [3:0] a, b, c, d, e);
    @(posedge clk);
    nrst <= 1'b0; f0 <= a; l0 <= b; f1 <= c; l1 <= d; sid <= e;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_straps(input logic [3:0] a, b, c, d, e);
    logic [47:0] fm, lv;
    boot(a, b, c, d, e);
    fm = {smask(c), smask(a)};
    lv = {smask(d), smask(b)};
    chk("oe", pin_oe, fm);
    chk("pins", pin_o, (fm & lv) | ~fm);
    chk("ident", {44'h0, ident}, {44'h0, ~e});
    bus(1'b0, 5'h18, 32'h0);
    chk("strap", {16'h0, got}, {28'h0, c, d, a, b, ~e});
    bus(1'b0, 5'h1c, 32'h0);
    chk("dir", {16'h0, got}, {40'h0, c, a});
    $display("strap test done");
  endtask
  task automatic t_soft;
    boot(4'h5, 4'h1, 4'h0, 4'h0, 4'hf);
    bus(1'b1, 5'h08, 32'h00123456);
    bus(1'b1, 5'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk("oe all out", {24'h0, pin_oe[23:0]}, 48'hffffff);
    chk("out", {24'h0, pin_o[23:0]}, 48'h123456);
    bus(1'b1, 5'h00, 32'h1b);
    repeat (2) @(posedge clk);
    chk("oe forced", {24'h0, pin_oe[23:0]}, {24'h0, smask(4'h5)});
    bus(1'b0, 5'h10, 32'h0);
    chk("in", {24'h0, got[23:0]}, {24'h0, (smask(4'h5) & 24'h123456) |
      (~smask(4'h5) & ext[23:0])});
    bus(1'b1, 5'h04, 32'h0a);
    repeat (2) @(posedge clk);
    chk("oe g1", {24'h0, pin_oe[47:24]}, {24'h0, smask(4'h9)});
    bus(1'b1, 5'h0c, 32'h00abcdef);
    bus(1'b0, 5'h0c, 32'h0);
    chk("out g1", {16'h0, got}, 48'habcdef);
    bus(1'b0, 5'h04, 32'h0);
    chk("ctrl g1", {16'h0, got}, 48'h0a);
    bus(1'b0, 5'h14, 32'h0);
    chk("in g1", {24'h0, got[23:0]}, {24'h0, (smask(4'h9) & 24'habcdef) |
      (~smask(4'h9) & ext[47:24])});
    bus(1'b1, 5'h18, 32'hffffffff);
    bus(1'b0, 5'h18, 32'h0);
    chk("strap kept", {16'h0, got}, 48'h510);
    $display("software test done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; addr = 5'h00; wdata = 32'h0;
    f0 = 4'h0; f1 = 4'h0; l0 = 4'h0; l1 = 4'h0; sid = 4'hf;
    ext = 48'h5a5aa5c3963c; bad_count = 0; n_compared = 0;
    t_straps(4'h1, 4'h1, 4'h2, 4'h0, 4'hf);
    t_straps(4'h2, 4'h0, 4'h4, 4'h4, 4'h0);
    t_straps(4'h4, 4'h4, 4'h8, 4'h8, 4'h5);
    t_straps(4'h8, 4'h0, 4'h1, 4'h0, 4'ha);
    t_straps(4'hf, 4'ha, 4'h0, 4'h0, 4'h3);
    t_soft;
    conclude;
  end
  // Watchdog
  initial begin
    #500000;
    bad_count++;
    conclude;
  end
endmodule
